// >>> occ_top.sv
// oscillator and system clock source control with AHB-Lite registers
//
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/100ps
module occ_top #(
  parameter logic       CFG_USE_CRYSTAL  = 1'b0,
  parameter logic [1:0] CFG_FAST_FREQ    = 2'h2
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        fast_rc_osc,
  input  wire logic        slow_rc_osc,
  input  wire logic        slow_crystal_osc,
  input  wire logic        halt_req,
  input  wire logic        wake_req,
  input  wire logic        crystal_pin_in,
  input  wire logic        gpio_out_a,
  input  wire logic        gpio_out_b,
  input  wire logic        gpio_oen_a,
  input  wire logic        gpio_oen_b,
  output logic             crystal_pin_out,
  output logic             crystal_pin_out_oen,
  output logic             crystal_pin_in_oen,
  output logic             crystal_pin_in_out,
  output logic             gpio_in_a,
  output logic             sysclk_en,
  output logic             low_speed_clock,
  output logic             high_speed_clock,
  output logic             wdt_clk_en,
  output logic             timebase_clk_en,
  output logic [1:0]       fast_rc_trim,
  output logic             crystal_low_power_sel,
  output logic             cpu_run
);
  // registers
  logic [2:0]  div_ff;
  logic        hl_ff;
  logic        idle_ff;
  logic [1:0]  freq_ff;
  logic        lp_ff;
  logic        syson_ff;
  logic        wr_pend_ff;
  logic [11:0] waddr_ff;
  occ_pkg::occ_mode_e mode_ff;
  occ_pkg::occ_mode_e nxt_mode;

  // derived
  logic        slow_tick;
  logic        div_tick;
  logic        fast_run;
  logic        slow_rdy;
  logic        fast_rdy;
  logic        slow_rdy_x;
  logic        slow_rdy_r;
  logic [31:0] system_mode_reg_val;
  logic [31:0] ctrl_val;
  logic        use_slow;
  logic        nxt_sysclk;

  if (CFG_FAST_FREQ > occ_pkg::FREQ_16MHZ)
  begin
    $error("occ_top: CFG_FAST_FREQ must be 8, 12 or 16 MHz code");
  end

  // slow source fixed at build time, one fast and one slow always present
  assign slow_tick = CFG_USE_CRYSTAL ? slow_crystal_osc : slow_rc_osc;
  assign fast_run  = (mode_ff == occ_pkg::OCC_FAST) ||
                     (mode_ff == occ_pkg::OCC_IDLE && syson_ff && !use_slow);

  function automatic logic [31:0] rd_mux(input logic [11:0] a,
                                         input logic [31:0] s,
                                         input logic [31:0] c);
    case (a)
      occ_pkg::SYSTEM_MODE_REG_OFS: rd_mux = s;
      occ_pkg::CTRL_OFS: rd_mux = c;
      default:           rd_mux = 32'h0000_0000;
    endcase
  endfunction

  // write strobe for one register offset
  function automatic logic wr_hit(input logic        pend,
                                  input logic [11:0] wa,
                                  input logic [11:0] ofs);
    wr_hit = pend && (wa == ofs);
  endfunction

  // fast path enable: undivided with high/low set, divider tick otherwise
  function automatic logic fast_pick(input logic hl,
                                     input logic fast,
                                     input logic div);
    fast_pick = hl ? fast : div;
  endfunction

  // bus write capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      waddr_ff   <= 12'h000;
    end
    else if (hready)
    begin
      wr_pend_ff <= hsel && htrans[1] && hwrite;
      waddr_ff   <= haddr[11:0];
    end
  end

  // mode register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_ff  <= occ_pkg::SYSTEM_MODE_REG_DIV_RST;
      hl_ff   <= occ_pkg::SYSTEM_MODE_REG_HL_RST;
      idle_ff <= occ_pkg::SYSTEM_MODE_REG_IDLE_RST;
    end
    else if (wr_hit(wr_pend_ff, waddr_ff, occ_pkg::SYSTEM_MODE_REG_OFS))
    begin
      div_ff  <= hwdata[occ_pkg::SYSTEM_MODE_REG_DIV_LSB +: 3];
      hl_ff   <= hwdata[occ_pkg::SYSTEM_MODE_REG_HL_BIT];
      idle_ff <= hwdata[occ_pkg::SYSTEM_MODE_REG_IDLE_BIT];
    end
  end

  // control register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      freq_ff  <= occ_pkg::CTRL_FREQ_RST;
      lp_ff    <= occ_pkg::CTRL_LP_RST;
      syson_ff <= occ_pkg::CTRL_SYSON_RST;
    end
    else if (wr_hit(wr_pend_ff, waddr_ff, occ_pkg::CTRL_OFS))
    begin
      freq_ff  <= hwdata[occ_pkg::CTRL_FREQ_LSB +: 2];
      lp_ff    <= hwdata[occ_pkg::CTRL_LP_BIT];
      syson_ff <= hwdata[occ_pkg::CTRL_SYSON_BIT];
    end
  end

  // operating mode
  always_comb
  begin
    nxt_mode = mode_ff;
    case (mode_ff)
      occ_pkg::OCC_FAST, occ_pkg::OCC_SLOW:
        if (halt_req)
          nxt_mode = idle_ff ? occ_pkg::OCC_IDLE : occ_pkg::OCC_SLEEP;
        else
          nxt_mode = use_slow ? occ_pkg::OCC_SLOW : occ_pkg::OCC_FAST;
      occ_pkg::OCC_IDLE, occ_pkg::OCC_SLEEP:
        if (wake_req)
          nxt_mode = use_slow ? occ_pkg::OCC_SLOW : occ_pkg::OCC_FAST;
      default:
        nxt_mode = occ_pkg::OCC_FAST;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mode_ff <= occ_pkg::OCC_FAST;
    else
      mode_ff <= nxt_mode;
  end

  // slow source for codes 000/001 with high/low bit clear
  assign use_slow = !hl_ff && (div_ff[2:1] == 2'b00);

  occ_div u_div
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .fast_tick (fast_rc_osc),
    .sel       (div_ff),
    .tick      (div_tick)
  );

  // ready counters: crystal needs 128 cycles, slow RC 2
  occ_ready #(
    .CYCLES (CFG_USE_CRYSTAL ? occ_pkg::CRYSTAL_READY_CYC : occ_pkg::SLOW_RC_READY_CYC)
  ) u_slow_rdy
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .run      (mode_ff != occ_pkg::OCC_SLEEP),
    .osc_tick (slow_tick),
    .ready    (slow_rdy_x)
  );

  occ_ready #(
    .CYCLES (occ_pkg::FAST_READY_CYC)
  ) u_fast_rdy
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .run      (fast_run),
    .osc_tick (fast_rc_osc),
    .ready    (fast_rdy)
  );

  assign slow_rdy = slow_rdy_x;
  assign slow_rdy_r = slow_rdy;

  always_comb
  begin
    system_mode_reg_val = 32'h0000_0000;
    system_mode_reg_val[occ_pkg::SYSTEM_MODE_REG_DIV_LSB +: 3]    = div_ff;
    system_mode_reg_val[occ_pkg::SYSTEM_MODE_REG_SLOW_RDY_BIT]    = slow_rdy_r;
    system_mode_reg_val[occ_pkg::SYSTEM_MODE_REG_FAST_RDY_BIT]    = fast_rdy;
    system_mode_reg_val[occ_pkg::SYSTEM_MODE_REG_IDLE_BIT]        = idle_ff;
    system_mode_reg_val[occ_pkg::SYSTEM_MODE_REG_HL_BIT]          = hl_ff;
    ctrl_val = 32'h0000_0000;
    ctrl_val[occ_pkg::CTRL_SYSON_BIT]       = syson_ff;
    ctrl_val[occ_pkg::CTRL_FREQ_LSB +: 2]   = freq_ff;
    ctrl_val[occ_pkg::CTRL_LP_BIT]          = CFG_USE_CRYSTAL & lp_ff;
  end

  // system clock enable selection
  always_comb
  begin
    case (mode_ff)
      occ_pkg::OCC_FAST:  nxt_sysclk = fast_pick(hl_ff, fast_rc_osc, div_tick);
      occ_pkg::OCC_SLOW:  nxt_sysclk = slow_tick;
      occ_pkg::OCC_IDLE:  nxt_sysclk = syson_ff && (use_slow ? slow_tick
                                                 : fast_pick(hl_ff, fast_rc_osc, div_tick));
      occ_pkg::OCC_SLEEP: nxt_sysclk = 1'b0;
      default:            nxt_sysclk = 1'b0;
    endcase
  end

  // registered outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata                <= 32'h0000_0000;
      sysclk_en             <= 1'b0;
      low_speed_clock       <= 1'b0;
      high_speed_clock      <= 1'b0;
      wdt_clk_en            <= 1'b0;
      timebase_clk_en       <= 1'b0;
      fast_rc_trim          <= occ_pkg::CTRL_FREQ_RST;
      crystal_low_power_sel <= occ_pkg::CTRL_LP_RST;
      cpu_run               <= 1'b0;
    end
    else
    begin
      if (hready && hsel && htrans[1] && !hwrite)
        hrdata <= rd_mux(haddr[11:0], system_mode_reg_val, ctrl_val);
      sysclk_en             <= nxt_sysclk;
      low_speed_clock       <= slow_tick;
      high_speed_clock      <= fast_run && fast_rc_osc;
      wdt_clk_en            <= slow_tick;
      timebase_clk_en       <= nxt_sysclk || slow_tick;
      fast_rc_trim          <= freq_ff;
      crystal_low_power_sel <= CFG_USE_CRYSTAL & lp_ff;
      cpu_run               <= (nxt_mode == occ_pkg::OCC_FAST) || (nxt_mode == occ_pkg::OCC_SLOW);
    end
  end

  // crystal pins: crystal or general I/O by build option, oen low = drive
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      crystal_pin_out     <= 1'b0;
      crystal_pin_out_oen <= 1'b1;
      crystal_pin_in_oen  <= 1'b1;
      crystal_pin_in_out  <= 1'b0;
      gpio_in_a           <= 1'b0;
    end
    else
    begin
      crystal_pin_out     <= CFG_USE_CRYSTAL ? 1'b0 : gpio_out_b;
      crystal_pin_out_oen <= CFG_USE_CRYSTAL ? 1'b1 : gpio_oen_b;
      crystal_pin_in_oen  <= CFG_USE_CRYSTAL ? 1'b1 : gpio_oen_a;
      crystal_pin_in_out  <= CFG_USE_CRYSTAL ? 1'b0 : gpio_out_a;
      gpio_in_a           <= CFG_USE_CRYSTAL ? 1'b0 : crystal_pin_in;
    end
  end

  // bus answer: zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule

// >>> occ_pkg.sv
// constants and types for the oscillator and clock-source control block
// Overview of operation
// - the fast RC oscillator runs at 8, 12 or 16 MHz, picked by a two-bit select field.
// - the system clock switches at run time between the fast path and the slow source.
// - the slow source, slow RC or crystal, is fixed by configuration and not by a register.
// - exactly one fast and one slow oscillator are always selected, never none.
// - the slow RC gives a nominal 32 kHz and the crystal a fixed 32.768 kHz.
// - the oscillators also clock the watchdog and the time base generators.
// - configuration gives the two crystal pins to the crystal or to general I/O.
// - crystal mode bit 0 is quick start, 1 is low power.
// - the crystal mode bit clears to zero at power-on.
// - the crystal clocks correctly in either mode; low power only starts slower.
// - the crystal output is valid only after its start-up delay.
// - in sleep, or in idle with CTRL_SYSON_BIT clear, the system clock stops while the slow clock keeps running.
// - with the high/low bit zero, codes 000/001 pick the slow clock, 010..111 fast/64..fast/2.
// - the slow ready flag is low in sleep and rises 128 crystal or 2 slow RC cycles after wake.
package occ_pkg;
  localparam logic [11:0] SYSTEM_MODE_REG_OFS          = 12'h000;
  localparam logic [11:0] CTRL_OFS          = 12'h004;
  localparam logic [11:0] STAT_OFS          = 12'h008;
  localparam int          SYSTEM_MODE_REG_HL_BIT       = 0;
  localparam int          SYSTEM_MODE_REG_IDLE_BIT     = 1;
  localparam int          SYSTEM_MODE_REG_FAST_RDY_BIT = 2;
  localparam int          SYSTEM_MODE_REG_SLOW_RDY_BIT = 3;
  localparam int          SYSTEM_MODE_REG_DIV_LSB      = 5;
  localparam int          CTRL_LP_BIT       = 3;
  localparam int          CTRL_FREQ_LSB     = 4;
  localparam int          CTRL_SYSON_BIT    = 7;
  localparam logic [2:0]  SYSTEM_MODE_REG_DIV_RST      = 3'h0;
  localparam logic        SYSTEM_MODE_REG_HL_RST       = 1'h1;
  localparam logic        SYSTEM_MODE_REG_IDLE_RST     = 1'h1;
  localparam logic [1:0]  CTRL_FREQ_RST     = 2'h0;
  localparam logic        CTRL_LP_RST       = 1'h0;
  localparam logic        CTRL_SYSON_RST    = 1'h0;
  localparam logic [1:0]  FREQ_8MHZ         = 2'h0;
  localparam logic [1:0]  FREQ_12MHZ        = 2'h1;
  localparam logic [1:0]  FREQ_16MHZ        = 2'h2;
  localparam int          CRYSTAL_READY_CYC = 128;
  localparam int          SLOW_RC_READY_CYC = 2;
  localparam int          FAST_READY_CYC    = 16;
  typedef enum logic [3:0]
  {
    OCC_FAST  = 4'h1,
    OCC_SLOW  = 4'h2,
    OCC_IDLE  = 4'h4,
    OCC_SLEEP = 4'h8
  } occ_mode_e;
endpackage

// >>> occ_div.sv
// divider producing fast/2..fast/64 enable pulses
`timescale 1ns/100ps
module occ_div
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       fast_tick,
  input  wire logic [2:0] sel,
  output logic            tick
);
  logic [5:0] cnt_ff;
  logic [5:0] mask;

  // code 111 -> /2 (mask 1), 010 -> /64 (mask 63)
  always_comb
  begin
    mask = 6'h3f >> (sel - 3'h2);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_ff <= 6'h00;
    else if (fast_tick)
      cnt_ff <= cnt_ff + 6'h01;
  end

  assign tick = fast_tick && ((cnt_ff & mask) == mask);
endmodule

// >>> occ_ready.sv
// start-up counter for an oscillator ready flag
`timescale 1ns/100ps
module occ_ready #(
  parameter int CYCLES = 128
)
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic run,
  input  wire logic osc_tick,
  output logic      ready
);
  logic [7:0] cnt_ff;
  logic       rdy_ff;

  if (CYCLES < 1 || CYCLES > 255)
  begin
    $error("occ_ready: CYCLES out of range");
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_ff <= 8'h00;
      rdy_ff <= 1'b0;
    end
    else if (!run)
    begin
      cnt_ff <= 8'h00;
      rdy_ff <= 1'b0;
    end
    else if (osc_tick && !rdy_ff)
    begin
      cnt_ff <= cnt_ff + 8'h01;
      if (cnt_ff == 8'(CYCLES - 1))
        rdy_ff <= 1'b1;
    end
  end

  assign ready = rdy_ff;
endmodule

// >>> occ_top_assertions.sv
// port-level checker for the oscillator and clock-source control block
`timescale 1ns/100ps
module occ_top_chk #(
  parameter logic CFG_USE_CRYSTAL = 1'b0
)
(
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       fast_rc_osc,
  input wire logic       slow_rc_osc,
  input wire logic       slow_crystal_osc,
  input wire logic       halt_req,
  input wire logic       cpu_run,
  input wire logic       crystal_pin_out_oen,
  input wire logic       crystal_pin_in_oen,
  input wire logic       gpio_in_a,
  input wire logic       sysclk_en,
  input wire logic       low_speed_clock,
  input wire logic [1:0] fast_rc_trim,
  input wire logic       crystal_low_power_sel
);
  logic wr;
  logic slow_src;
  assign wr = hsel & htrans[1] & hwrite;
  assign slow_src = CFG_USE_CRYSTAL ? slow_crystal_osc : slow_rc_osc;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence halt_taken;
    halt_req && cpu_run;
  endsequence
  sequence cpu_stops;
    ##[1:3] !cpu_run;
  endsequence
  sequence wr_recent;
    $past(wr) || $past(wr, 2) || $past(wr, 3) || $past(wr, 4);
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  pin_release_a: assert property (CFG_USE_CRYSTAL |-> crystal_pin_out_oen && crystal_pin_in_oen)
    else $error("crystal pin driven in crystal mode");
  gpio_block_a: assert property (CFG_USE_CRYSTAL |-> !gpio_in_a)
    else $error("pin level leaks to io in crystal mode");
  halt_stop_a: assert property (halt_taken |-> cpu_stops)
    else $error("cpu still running after halt");
  low_src_a: assert property (low_speed_clock |-> $past(slow_src) || $past(slow_src, 2))
    else $error("slow clock pulse without configured source tick");
  sysclk_src_a: assert property (sysclk_en |-> $past(fast_rc_osc) || $past(fast_rc_osc, 2)
    || $past(slow_src) || $past(slow_src, 2))
    else $error("system clock pulse without source tick");
  trim_write_a: assert property ($changed(fast_rc_trim) |-> wr_recent)
    else $error("fast trim changed without a write");
  lp_write_a: assert property ($rose(crystal_low_power_sel) |-> wr_recent)
    else $error("low power mode set without a write");
endmodule

bind occ_top occ_top_chk #(.CFG_USE_CRYSTAL(CFG_USE_CRYSTAL)) u_chk (.hclk, .hresetn, .hsel,
  .htrans, .hwrite, .hreadyout, .hresp, .fast_rc_osc, .slow_rc_osc, .slow_crystal_osc,
  .halt_req, .cpu_run, .crystal_pin_out_oen, .crystal_pin_in_oen, .gpio_in_a, .sysclk_en,
  .low_speed_clock, .fast_rc_trim, .crystal_low_power_sel);

// >>> occ_osc_model.sv
// free-running oscillator and crystal tick model
`timescale 1ns/100ps
module occ_osc_model #(
  parameter int FAST_DIV = 2,
  parameter int RC_DIV   = 6,
  parameter int XT_DIV   = 8
)
(
  input wire logic hclk,
  output logic     fast_rc_osc,
  output logic     slow_rc_osc,
  output logic     slow_crystal_osc,
  output logic     crystal_pin_in
);
  int n;
  initial
  begin
    n = 0;
    fast_rc_osc = 1'b0;
    slow_rc_osc = 1'b0;
    slow_crystal_osc = 1'b0;
    crystal_pin_in = 1'b0;
  end
  // the fast source and both slow sources, RC and crystal, always present
  always @(posedge hclk)
  begin
    n <= n + 1;
    fast_rc_osc <= (n % FAST_DIV) == 0;
    slow_rc_osc <= (n % RC_DIV) == 0;
    slow_crystal_osc <= (n % XT_DIV) == 0;
    if ((n % XT_DIV) == 0)
    begin
      crystal_pin_in <= !crystal_pin_in;
    end
  end
endmodule

// >>> occ_top_tb.sv
// testbench for the oscillator and clock-source control block
`timescale 1ns/100ps
module occ_top_tb;
  logic hclk, hresetn, hsel, hwrite, halt_req, wake_req, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans, fast_rc_trim;
  logic [2:0]  hsize;
  logic fast_rc_osc, slow_rc_osc, slow_crystal_osc, crystal_pin_in, sysclk_en, cpu_run;
  logic low_speed_clock, wdt_clk_en, crystal_low_power_sel, high_speed_clock, timebase_clk_en;
  logic gpio_a, pin_out, pin_in_out;
  int fails, n_checks, cyc, c_sys, c_low, c_wdt, c_hs, c_tb;
  localparam logic [31:0] A_SYSTEM_MODE_REG = 32'(occ_pkg::SYSTEM_MODE_REG_OFS);
  localparam logic [31:0] A_CTRL = 32'(occ_pkg::CTRL_OFS);
  occ_osc_model osc (.hclk, .fast_rc_osc, .slow_rc_osc, .slow_crystal_osc, .crystal_pin_in);
  occ_top #(.CFG_USE_CRYSTAL(1'b1), .CFG_FAST_FREQ(2'h2)) uut (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .fast_rc_osc, .slow_rc_osc, .slow_crystal_osc, .halt_req, .wake_req,
    .crystal_pin_in, .gpio_out_a(gpio_a), .gpio_out_b(1'b0), .gpio_oen_a(1'b0),
    .gpio_oen_b(1'b1), .crystal_pin_out(pin_out), .crystal_pin_out_oen(),
    .crystal_pin_in_oen(), .crystal_pin_in_out(pin_in_out), .gpio_in_a(), .sysclk_en,
    .low_speed_clock, .high_speed_clock, .wdt_clk_en, .timebase_clk_en, .fast_rc_trim,
    .crystal_low_power_sel, .cpu_run);
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = !hclk;
  end
  task automatic conclude;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic rng(input int got, input int exp);
    n_checks++;
    if (got < exp - 1 || got > exp + 1)
    begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic pulses(input int n);
    c_sys = 0;
    c_low = 0;
    c_wdt = 0;
    c_hs = 0;
    c_tb = 0;
    repeat (n)
    begin
      @(posedge hclk);
      #1;
      c_sys += int'(sysclk_en === 1'b1);
      c_low += int'(low_speed_clock === 1'b1);
      c_wdt += int'(wdt_clk_en === 1'b1);
      c_hs += int'(high_speed_clock === 1'b1);
      c_tb += int'(timebase_clk_en === 1'b1);
    end
  endtask
  task automatic halt_wake(input logic wake);
    @(posedge hclk);
    if (wake) wake_req <= 1'b1; else halt_req <= 1'b1;
    @(posedge hclk);
    wake_req <= 1'b0;
    halt_req <= 1'b0;
  endtask
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      conclude();
    end
  end
  initial
  begin
    {hresetn, hsel, hwrite, halt_req, wake_req, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    gpio_a = 1'b1;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, A_SYSTEM_MODE_REG, 32'h0);
    chk(q & 32'hffff_fff3, 32'h3);
    chk({30'h0, pin_out, pin_in_out}, 32'h0);
    pulses(600);
    bus(1'b0, A_SYSTEM_MODE_REG, 32'h0);
    chk(q, 32'h7);
    pulses(600);
    bus(1'b0, A_SYSTEM_MODE_REG, 32'h0);
    chk(q, 32'hf);
    bus(1'b0, A_CTRL, 32'h0);
    chk(q, 32'h0);
    for (int f = 0; f < 3; f++)
    begin
      bus(1'b1, A_CTRL, 32'(f) << occ_pkg::CTRL_FREQ_LSB);
      bus(1'b0, A_CTRL, 32'h0);
      chk(q, 32'(f) << occ_pkg::CTRL_FREQ_LSB);
      chk({30'h0, fast_rc_trim}, 32'(f));
    end
    bus(1'b1, A_CTRL, 32'h8);
    bus(1'b0, A_CTRL, 32'h0);
    chk(q, 32'h8);
    chk({31'h0, crystal_low_power_sel}, 32'h1);
    bus(1'b1, 32'h8, 32'hffff_ffff);
    bus(1'b0, 32'h8, 32'h0);
    chk(q, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      bus(1'b1, A_SYSTEM_MODE_REG, (32'(k) << occ_pkg::SYSTEM_MODE_REG_DIV_LSB) | 32'h2);
      pulses(512);
      rng(c_sys, (k < 2) ? 64 : (256 >> (8 - k)));
    end
    bus(1'b1, A_SYSTEM_MODE_REG, 32'he3);
    pulses(512);
    rng(c_sys, 256);
    rng(c_wdt, 64);
    rng(c_hs, 256);
    rng(c_tb, 256);
    bus(1'b1, A_SYSTEM_MODE_REG, 32'h0);
    halt_wake(1'b0);
    pulses(64);
    chk({31'h0, cpu_run}, 32'h0);
    rng(c_sys, 0);
    rng(c_low, 8);
    rng(c_hs, 0);
    rng(c_tb, 8);
    bus(1'b0, A_SYSTEM_MODE_REG, 32'h0);
    chk(q & 32'h8, 32'h0);
    halt_wake(1'b1);
    pulses(800);
    bus(1'b0, A_SYSTEM_MODE_REG, 32'h0);
    chk(q & 32'h8, 32'h0);
    pulses(320);
    bus(1'b0, A_SYSTEM_MODE_REG, 32'h0);
    chk(q & 32'h8, 32'h8);
    chk({31'h0, cpu_run}, 32'h1);
    bus(1'b1, A_SYSTEM_MODE_REG, 32'h3);
    for (int s = 0; s < 2; s++)
    begin
      bus(1'b1, A_CTRL, (32'(s) << occ_pkg::CTRL_SYSON_BIT) | 32'h20);
      halt_wake(1'b0);
      pulses(64);
      rng(c_sys, s * 32);
      halt_wake(1'b1);
      pulses(16);
    end
    conclude();
  end
endmodule
